// ===== hdl/sac_pkg.sv
// package: register map, field layout and timing constants of the converter control block
`default_nettype none
package sac_pkg;
	// register byte addresses (word aligned)
	localparam logic [3:0] OFS_STATUS_CONTROL = 4'h0;
	localparam logic [3:0] OFS_RESULT         = 4'h4;
	localparam logic [3:0] OFS_CLOCK_CONFIG   = 4'h8;
	localparam logic [3:0] OFS_PORT_DATA      = 4'hC;
	// status/control layout
	localparam int         BIT_DONE  = 7;
	localparam int         BIT_IRQEN = 6;
	localparam int         BIT_CONT  = 5;
	localparam logic [4:0] RST_CHAN  = 5'h1F;
	// clock config layout: divider [7:5], source select [4]
	localparam int         DIV_LSB   = 5;
	localparam int         BIT_SRC   = 4;
	localparam logic [2:0] RST_DIV   = 3'h0;
	localparam logic       RST_SRC   = 1'b0;
	// channel codes
	localparam logic [4:0] CHAN_LAST = 5'h07;
	localparam logic [4:0] CHAN_REFH = 5'h1D;
	localparam logic [4:0] CHAN_REFL = 5'h1E;
	localparam logic [4:0] CHAN_OFF  = 5'h1F;
	// one conversion: 16 to 17 converter clock ticks
	localparam int         CONV_TICKS = 16;
	localparam logic [7:0] FULL_SCALE = 8'hFF;
	localparam logic [7:0] ZERO_SCALE = 8'h00;
	typedef enum logic [1:0] {
		SAC_IDLE,
		SAC_SYNC,
		SAC_RUN
	} sac_state_t;
endpackage : sac_pkg
`default_nettype wire

// ===== hdl/sac_clk_div.sv
// converter clock tick generator: source select plus power-of-two divider
`default_nettype none
module sac_clk_div #(
	parameter int DIV_W = 4
) (
	// clock and reset
	input  wire logic       clock_in,
	input  wire logic       rst_b_in,
	// configuration
	input  wire logic [2:0] divide_in,
	input  wire logic       source_bus_in,
	input  wire logic       osc_tick_in,
	input  wire logic       restart_in,
	// tick
	output logic            tick_out
);
	logic [DIV_W-1:0] count_ff;
	logic [DIV_W-1:0] nxt_count;
	logic [DIV_W-1:0] ratio_m1;
	logic             src_tick;
	logic             nxt_tick;
	logic             tick_ff;

	always_comb begin
		src_tick = source_bus_in ? 1'b1 : osc_tick_in;
		case (divide_in)
			3'h0:    ratio_m1 = DIV_W'(0);
			3'h1:    ratio_m1 = DIV_W'(1);
			3'h2:    ratio_m1 = DIV_W'(3);
			3'h3:    ratio_m1 = DIV_W'(7);
			default: ratio_m1 = DIV_W'(15);
		endcase
		nxt_count = count_ff;
		nxt_tick  = 1'b0;
		if (restart_in) begin
			nxt_count = '0;
		end else if (src_tick) begin
			if (count_ff >= ratio_m1) begin
				nxt_count = '0;
				nxt_tick  = 1'b1;
			end else begin
				nxt_count = count_ff + DIV_W'(1);
			end
		end
	end

	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			count_ff <= '0;
			tick_ff  <= 1'b0;
		end else begin
			count_ff <= nxt_count;
			tick_ff  <= nxt_tick;
		end
	end

	assign tick_out = tick_ff;
endmodule : sac_clk_div
`default_nettype wire

// ===== hdl/sac_conv_ctrl.sv
// converter control: registers, sequencing, pin override and completion logic
// Overview of operation
// - results are 8-bit values from one successive-approximation converter
// - channel select routes exactly one of eight channels to the converter
// - the selected channel's port pin is forced to analogue input
// - unselected port pins stay under normal port control
// - port data and direction writes do not affect the selected pin
// - port reads of the selected pin return zero
// - high reference gives full scale, low reference zero, linear between
// - any status/control write not selecting all ones starts a conversion of 16 to 17 ticks
// - continuous mode overwrites the result every conversion
// - continuous conversions repeat until the continuous bit clears
// - continuous mode with interrupts off sets done after first conversion, cleared by write/read
// - single mode does one conversion per write, then idles
// - interrupts off: done is read-only, set per single-mode conversion and first continuous one, cleared by write/read
// - interrupt enabled: request an interrupt at every conversion end while done is zero
// - interrupts on: done flag is software read/write; software keeps it zero
// - result read or status/control write withdraws the pending request
// - reset clears done flag, interrupt enable and continuous bit
// - converter runs in wait mode; enabled interrupt can wake the cpu
// - stop mode aborts conversion; conversions resume after stop ends
// - channel codes 0-7 pins, then high ref, low ref; all ones is off
// - divider field divides by 1, 2, 4, 8; top bit set divides by 16
// - source select one picks bus clock, zero oscillator; reset oscillator
`default_nettype none
module sac_conv_ctrl #(
	parameter int CHANNELS = 8
) (
	// clock and reset
	input  wire logic                clock_in,
	input  wire logic                rst_b_in,
	// avalon-mm slave
	input  wire logic [3:0]          avs_address_in,
	input  wire logic                avs_read_in,
	input  wire logic                avs_write_in,
	input  wire logic [31:0]         avs_writedata_in,
	output logic      [31:0]         avs_readdata_out,
	output logic                     avs_waitrequest_out,
	// converter core
	input  wire logic [7:0]          sar_result_in,
	input  wire logic                osc_tick_in,
	output logic      [4:0]          mux_select_out,
	output logic                     sar_start_out,
	output logic                     sar_power_out,
	// shared port pins
	input  wire logic [CHANNELS-1:0] pin_in,
	input  wire logic [CHANNELS-1:0] port_out_in,
	input  wire logic [CHANNELS-1:0] port_oe_in,
	output logic      [CHANNELS-1:0] pin_out,
	output logic      [CHANNELS-1:0] pin_oe_out,
	output logic      [CHANNELS-1:0] analog_enable_out,
	output logic      [CHANNELS-1:0] port_read_out,
	// low power and interrupt
	input  wire logic                stop_mode_in,
	output logic                     irq_out
);
	logic                  done_ff, irqen_ff, cont_ff;
	logic [4:0]            chan_ff;
	logic [7:0]            result_ff;
	logic [2:0]            div_ff;
	logic                  src_ff;
	logic                  nxt_done, nxt_irqen, nxt_cont, nxt_src;
	logic [4:0]            nxt_chan;
	logic [7:0]            nxt_result;
	logic [2:0]            nxt_div;
	sac_pkg::sac_state_t   state_ff, nxt_state;
	logic [4:0]            ticks_ff, nxt_ticks;
	logic                  first_ff, nxt_first;
	logic                  irq_ff, nxt_irq;
	logic [31:0]           rdata_ff, nxt_rdata;
	logic                  wait_ff, nxt_wait;
	logic                  start_ff, nxt_start;
	logic                  power_ff, nxt_power;
	logic [CHANNELS-1:0]   pin_s1_ff, pin_s2_ff;
	logic [CHANNELS-1:0]   pout_ff, poe_ff, aen_ff, prd_ff;
	logic [CHANNELS-1:0]   nxt_pout, nxt_poe, nxt_aen, nxt_prd;
	logic                  stop_s1_ff, stop_s2_ff;
	logic                  sc_wr, res_rd, acc, finish, tick, pin_sel;
	logic [CHANNELS-1:0]   sel_mask;

	// single-cycle accept: waitrequest high only on the access's first cycle
	assign acc    = (avs_read_in | avs_write_in) & wait_ff;
	assign sc_wr  = acc & avs_write_in & (avs_address_in == sac_pkg::OFS_STATUS_CONTROL);
	assign res_rd = acc & avs_read_in & (avs_address_in == sac_pkg::OFS_RESULT);
	assign pin_sel = (chan_ff <= sac_pkg::CHAN_LAST);

	sac_clk_div u_div (
		.clock_in      (clock_in),
		.rst_b_in      (rst_b_in),
		.divide_in     (div_ff),
		.source_bus_in (src_ff),
		.osc_tick_in   (osc_tick_in),
		.restart_in    (sc_wr),
		.tick_out      (tick)
	);

	// bus front end and register file
	always_comb begin
		nxt_wait  = 1'b1;
		nxt_rdata = rdata_ff;
		nxt_irqen = irqen_ff;
		nxt_cont  = cont_ff;
		nxt_chan  = chan_ff;
		nxt_div   = div_ff;
		nxt_src   = src_ff;
		if ((avs_read_in | avs_write_in) & wait_ff) begin
			nxt_wait = 1'b0;
		end
		if (acc & avs_read_in) begin
			case (avs_address_in)
				sac_pkg::OFS_STATUS_CONTROL:
					nxt_rdata = {24'h000000, done_ff, irqen_ff, cont_ff, chan_ff};
				sac_pkg::OFS_RESULT:
					nxt_rdata = {24'h000000, result_ff};
				sac_pkg::OFS_CLOCK_CONFIG:
					nxt_rdata = {24'h000000, div_ff, src_ff, 4'h0};
				sac_pkg::OFS_PORT_DATA:
					nxt_rdata = {{(32-CHANNELS){1'b0}}, prd_ff};
				default:
					nxt_rdata = 32'h00000000;
			endcase
		end
		if (sc_wr) begin
			nxt_irqen = avs_writedata_in[sac_pkg::BIT_IRQEN];
			nxt_cont  = avs_writedata_in[sac_pkg::BIT_CONT];
			nxt_chan  = avs_writedata_in[4:0];
		end
		if (acc & avs_write_in & (avs_address_in == sac_pkg::OFS_CLOCK_CONFIG)) begin
			nxt_div = avs_writedata_in[sac_pkg::DIV_LSB +: 3];
			nxt_src = avs_writedata_in[sac_pkg::BIT_SRC];
		end
		// registered so the core enable never glitches on a channel change
		nxt_power = (nxt_chan != sac_pkg::CHAN_OFF);
	end

	// conversion sequencer; stop aborts, restart is a fresh write
	always_comb begin
		nxt_state  = state_ff;
		nxt_ticks  = ticks_ff;
		nxt_first  = first_ff;
		nxt_result = result_ff;
		nxt_start  = 1'b0;
		finish     = 1'b0;
		if (stop_s2_ff) begin
			// aborted work restarts from scratch once stop ends
			nxt_state = (state_ff == sac_pkg::SAC_IDLE) ? sac_pkg::SAC_IDLE : sac_pkg::SAC_SYNC;
			nxt_ticks = 5'h00;
		end else if (sc_wr) begin
			nxt_state = sac_pkg::SAC_SYNC;
			nxt_ticks = 5'h00;
			nxt_first = 1'b1;
		end else begin
			case (state_ff)
				sac_pkg::SAC_IDLE: nxt_state = sac_pkg::SAC_IDLE;
				sac_pkg::SAC_SYNC: begin
					// wait for the first tick so the count is 16 or 17 ticks
					if (tick & chan_ff != sac_pkg::CHAN_OFF) begin
						nxt_state = sac_pkg::SAC_RUN;
						nxt_start = 1'b1;
						nxt_ticks = 5'h01;
					end
				end
				sac_pkg::SAC_RUN: begin
					if (tick) begin
						nxt_ticks = ticks_ff + 5'h01;
						if (ticks_ff == 5'(sac_pkg::CONV_TICKS)) begin
							finish = 1'b1;
							case (chan_ff)
								sac_pkg::CHAN_REFH: nxt_result = sac_pkg::FULL_SCALE;
								sac_pkg::CHAN_REFL: nxt_result = sac_pkg::ZERO_SCALE;
								default:            nxt_result = sar_result_in;
							endcase
							nxt_first = 1'b0;
							nxt_state = cont_ff ? sac_pkg::SAC_SYNC : sac_pkg::SAC_IDLE;
							nxt_ticks = 5'h00;
						end
					end
				end
				default: nxt_state = sac_pkg::SAC_IDLE;
			endcase
		end
	end

	// done flag and interrupt; a finish in the clearing cycle wins
	always_comb begin
		nxt_done = done_ff;
		nxt_irq  = irq_ff;
		if (sc_wr) begin
			nxt_done = irqen_ff ? avs_writedata_in[sac_pkg::BIT_DONE] : 1'b0;
		end
		if (res_rd & !irqen_ff) begin
			nxt_done = 1'b0;
		end
		if (sc_wr | res_rd) begin
			nxt_irq = 1'b0;
		end
		if (finish & !irqen_ff & (first_ff | !cont_ff)) begin
			nxt_done = 1'b1;
		end
		if (finish & irqen_ff & !done_ff) begin
			nxt_irq = 1'b1;
		end
		if (!nxt_irqen) begin
			nxt_irq = 1'b0;
		end
	end

	// pin override
	always_comb begin
		sel_mask = '0;
		if (pin_sel) begin
			sel_mask[chan_ff[2:0]] = 1'b1;
		end
		nxt_aen  = sel_mask;
		nxt_pout = port_out_in & ~sel_mask;
		nxt_poe  = port_oe_in & ~sel_mask;
		nxt_prd  = pin_s2_ff & ~sel_mask;
	end

	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			done_ff    <= 1'b0;
			irqen_ff   <= 1'b0;
			cont_ff    <= 1'b0;
			chan_ff    <= sac_pkg::RST_CHAN;
			div_ff     <= sac_pkg::RST_DIV;
			src_ff     <= sac_pkg::RST_SRC;
			result_ff  <= 8'h00;
			state_ff   <= sac_pkg::SAC_IDLE;
			ticks_ff   <= 5'h00;
			first_ff   <= 1'b0;
			irq_ff     <= 1'b0;
			rdata_ff   <= 32'h00000000;
			wait_ff    <= 1'b1;
			start_ff   <= 1'b0;
			power_ff   <= 1'b0;
			pin_s1_ff  <= '0;
			pin_s2_ff  <= '0;
			stop_s1_ff <= 1'b0;
			stop_s2_ff <= 1'b0;
			pout_ff    <= '0;
			poe_ff     <= '0;
			aen_ff     <= '0;
			prd_ff     <= '0;
		end else begin
			done_ff    <= nxt_done;
			irqen_ff   <= nxt_irqen;
			cont_ff    <= nxt_cont;
			chan_ff    <= nxt_chan;
			div_ff     <= nxt_div;
			src_ff     <= nxt_src;
			result_ff  <= nxt_result;
			state_ff   <= nxt_state;
			ticks_ff   <= nxt_ticks;
			first_ff   <= nxt_first;
			irq_ff     <= nxt_irq;
			rdata_ff   <= nxt_rdata;
			wait_ff    <= nxt_wait;
			start_ff   <= nxt_start;
			power_ff   <= nxt_power;
			pin_s1_ff  <= pin_in;
			pin_s2_ff  <= pin_s1_ff;
			stop_s1_ff <= stop_mode_in;
			stop_s2_ff <= stop_s1_ff;
			pout_ff    <= nxt_pout;
			poe_ff     <= nxt_poe;
			aen_ff     <= nxt_aen;
			prd_ff     <= nxt_prd;
		end
	end

	assign avs_readdata_out    = rdata_ff;
	assign avs_waitrequest_out = wait_ff;
	assign mux_select_out      = chan_ff;
	assign sar_start_out       = start_ff;
	assign sar_power_out       = power_ff;
	assign pin_out             = pout_ff;
	assign pin_oe_out          = poe_ff;
	assign analog_enable_out   = aen_ff;
	assign port_read_out       = prd_ff;
	assign irq_out             = irq_ff;

	// checks
	int unsigned run_len;
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			run_len <= 0;
		end else if (sc_wr | finish | stop_s2_ff | state_ff == sac_pkg::SAC_IDLE) begin
			run_len <= 0;
		end else begin
			run_len <= run_len + 1;
		end
	end

	irq_needs_en_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
		irq_ff |-> irqen_ff) else $error("irq high with interrupts off");
	irq_clear_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
		(sc_wr | res_rd) & !finish |=> !irq_ff) else $error("irq not withdrawn");
	irq_set_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
		finish & irqen_ff & nxt_irqen & !done_ff |=> irq_ff) else $error("irq missing");
	done_set_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
		finish & !irqen_ff & !cont_ff |=> done_ff) else $error("done not set");
	done_wr_clr_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
		sc_wr & !irqen_ff |=> !done_ff) else $error("done not cleared by write");
	cont_done_hold_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
		finish & cont_ff & !first_ff & !irqen_ff & !res_rd |=> done_ff == $past(done_ff))
		else $error("done set again in continuous mode");
	done_clr_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
		res_rd & !irqen_ff & !finish |=> !done_ff) else $error("done not cleared");
	result_upd_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
		finish & chan_ff == sac_pkg::CHAN_REFH |=> result_ff == 8'hFF)
		else $error("reference high not full scale");
	single_idle_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
		finish & !cont_ff & !sc_wr & !stop_s2_ff |=> state_ff == sac_pkg::SAC_IDLE)
		else $error("single mode kept running");
	cont_again_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
		finish & cont_ff & !sc_wr & !stop_s2_ff |=> state_ff == sac_pkg::SAC_SYNC)
		else $error("continuous mode stopped");
	stop_abort_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
		stop_s2_ff |=> state_ff != sac_pkg::SAC_RUN) else $error("stop did not abort");
	power_start_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
		start_ff |-> power_ff) else $error("start with converter off");
	aen_onehot_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
		$onehot0(aen_ff)) else $error("more than one pin forced analogue");
	pin_read_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
		pin_sel & !sc_wr |=> (prd_ff & aen_ff) == '0) else $error("selected pin reads one");
	run_len_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
		finish & src_ff & div_ff == 3'h0 |-> run_len >= 16 && run_len <= 18)
		else $error("conversion length out of range");
	single_cov: cover property (@(posedge clock_in) finish & !cont_ff);
	cont_cov: cover property (@(posedge clock_in) finish & cont_ff & !first_ff);
	irq_cov: cover property (@(posedge clock_in) irq_ff ##1 !irq_ff);
	restart_cov: cover property (@(posedge clock_in) state_ff == sac_pkg::SAC_RUN & sc_wr);
	stop_cov: cover property (@(posedge clock_in) stop_s2_ff & state_ff == sac_pkg::SAC_SYNC);
endmodule : sac_conv_ctrl
`default_nettype wire

// ===== bench/sac_far_model.sv
// far-side model: converter core, oscillator tick and shared pin wiring
`default_nettype none
module sac_far_model (
	// clock and reset
	input  wire logic       clock_in,
	input  wire logic       rst_b_in,
	// converter core side
	input  wire logic [4:0] mux_select_in,
	input  wire logic       sar_power_in,
	input  wire logic [7:0] level_ofs_in,
	output logic      [7:0] sar_result_out,
	output logic            osc_tick_out,
	// shared pins
	input  wire logic [7:0] pin_drive_in,
	input  wire logic [7:0] pin_oe_in,
	output logic      [7:0] pin_level_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// level seen on pins that nobody drives
	localparam logic [7:0] EXT_LEVEL = 8'hA5;
	logic [7:0] junk_ff;
	// oscillator at half the system clock, so divider ratios stay visible
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			osc_tick_out <= 1'b0;
			junk_ff      <= 8'h3C;
		end else begin
			osc_tick_out <= ~osc_tick_out;
			junk_ff      <= junk_ff + 8'h5B;
		end
	end
	// a core that is off never shows a stable value
	always_comb begin
		if (!sar_power_in) begin
			sar_result_out = junk_ff;
		end else if (mux_select_in == 5'h1D) begin
			sar_result_out = 8'hFF;
		end else if (mux_select_in == 5'h1E) begin
			sar_result_out = 8'h00;
		end else begin
			sar_result_out = {mux_select_in[3:0], mux_select_in[3:0]} + level_ofs_in;
		end
	end
	assign pin_level_out = (pin_oe_in & pin_drive_in) | (~pin_oe_in & EXT_LEVEL);
endmodule : sac_far_model
`default_nettype wire

// ===== bench/tb_top.sv
// self-checking bench for the converter control block
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock_in = 1'b0, rst_b_in = 1'b0;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0, avs_write = 1'b0, irq_out, osc_tick, sar_start, sar_power;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
	logic avs_waitrequest, stop_mode = 1'b0;
	logic [7:0] sar_result, level_ofs = 8'h00, pin_level, pin_out, pin_oe, an_en, port_rd;
	logic [7:0] port_out = 8'h0A, port_oe = 8'h0F, sel, pins;
	logic [4:0] mux_select;
	int err_count = 0, tests_run = 0, starts = 0;
	logic [4:0] codes [10] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h1D, 5'h1E};
	int ratio [6] = '{1, 2, 4, 8, 16, 16};
	logic [2:0] divs [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
	always #10 clock_in = ~clock_in;
	always @(negedge clock_in) if (sar_start === 1'b1) starts++;
	sac_conv_ctrl i_dut (.clock_in(clock_in), .rst_b_in(rst_b_in), .avs_address_in(avs_address),
		.avs_read_in(avs_read), .avs_write_in(avs_write), .avs_writedata_in(avs_writedata),
		.avs_readdata_out(avs_readdata), .avs_waitrequest_out(avs_waitrequest),
		.sar_result_in(sar_result), .osc_tick_in(osc_tick), .mux_select_out(mux_select),
		.sar_start_out(sar_start), .sar_power_out(sar_power), .pin_in(pin_level),
		.port_out_in(port_out), .port_oe_in(port_oe), .pin_out(pin_out), .pin_oe_out(pin_oe),
		.analog_enable_out(an_en), .port_read_out(port_rd), .stop_mode_in(stop_mode),
		.irq_out(irq_out));
	sac_far_model i_far (.clock_in(clock_in), .rst_b_in(rst_b_in), .mux_select_in(mux_select),
		.sar_power_in(sar_power), .level_ofs_in(level_ofs), .sar_result_out(sar_result),
		.osc_tick_out(osc_tick), .pin_drive_in(pin_out), .pin_oe_in(pin_oe),
		.pin_level_out(pin_level));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : wrap_up
	task automatic cycles(input int n);
		repeat (n) @(negedge clock_in);
	endtask : cycles
	// sampled on the falling edge: the value the next rising edge will see
	task automatic bus_access(input logic [3:0] a, input logic wr, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clock_in);
		avs_address   <= a;
		avs_writedata <= {24'h0, d};
		avs_read      <= ~wr;
		avs_write     <= wr;
		do begin
			@(negedge clock_in);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		check(n < 50, 1'b1);
		@(posedge clock_in);
		rd = avs_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus_access
	task automatic bus_write(input logic [3:0] a, input logic [7:0] d);
		bus_access(a, 1'b1, d);
	endtask : bus_write
	task automatic bus_read(input logic [3:0] a, input logic [31:0] exp);
		bus_access(a, 1'b0, 8'h00);
		check(rd, exp);
	endtask : bus_read
	// span is converter clock ratio times source period, in system cycles
	task automatic conv_time(input logic [7:0] ctl, input int span);
		int n;
		n = 0;
		bus_write(sac_pkg::OFS_STATUS_CONTROL, ctl);
		while (irq_out !== 1'b1 && n < 3000) begin
			@(negedge clock_in);
			n++;
		end
		check(n >= 16 * span - 2 && n <= 18 * span + 6, 1'b1);
	endtask : conv_time
	initial begin
		#400000;
		err_count++;
		wrap_up();
	end
	initial begin
		cycles(20);
		@(posedge clock_in);
		rst_b_in <= 1'b1;
		check(irq_out, 1'b0);
		check(sar_power, 1'b0);
		bus_read(sac_pkg::OFS_STATUS_CONTROL, 32'h1F);
		bus_read(sac_pkg::OFS_CLOCK_CONFIG, 32'h00);
		bus_read(4'h2, 32'h0);
		bus_read(4'h6, 32'h0);
		// oscillator source, divider settings 0 to 4 and 7
		for (int i = 0; i < 6; i++) begin
			bus_write(sac_pkg::OFS_CLOCK_CONFIG, {divs[i], 5'h00});
			conv_time(8'h41, ratio[i] * 2);
			bus_read(sac_pkg::OFS_RESULT, 32'h11);
		end
		bus_write(sac_pkg::OFS_CLOCK_CONFIG, 8'h10);
		bus_read(sac_pkg::OFS_CLOCK_CONFIG, 32'h10);
		for (int i = 0; i < 10; i++) begin
			conv_time({3'b010, codes[i]}, 1);
			sel = (codes[i] <= 5'h07) ? (8'h01 << codes[i]) : 8'h00;
			pins = (port_oe & ~sel & port_out) | (~(port_oe & ~sel) & 8'hA5);
			check(mux_select, codes[i]);
			check(sar_power, 1'b1);
			check(an_en, sel);
			check(pin_oe, port_oe & ~sel);
			check(pin_out, port_out & ~sel);
			check(port_rd, pins & ~sel);
			cycles(10);
			check(irq_out, 1'b1);
			bus_read(sac_pkg::OFS_PORT_DATA, {24'h0, pins & ~sel});
			bus_read(sac_pkg::OFS_RESULT, (codes[i] == 5'h1D) ? 32'hFF :
				(codes[i] == 5'h1E) ? 32'h00 : {24'h0, codes[i][3:0], codes[i][3:0]});
			cycles(1);
			check(irq_out, 1'b0);
		end
		// single mode stays idle afterwards
		conv_time(8'h43, 1);
		starts = 0;
		cycles(80);
		check(starts, 0);
		bus_write(sac_pkg::OFS_STATUS_CONTROL, 8'h03);
		cycles(1);
		check(irq_out, 1'b0);
		// done bit read-only with interrupts off
		bus_write(sac_pkg::OFS_STATUS_CONTROL, 8'h82);
		bus_read(sac_pkg::OFS_STATUS_CONTROL, 32'h02);
		cycles(40);
		check(irq_out, 1'b0);
		bus_read(sac_pkg::OFS_STATUS_CONTROL, 32'h82);
		bus_write(sac_pkg::OFS_RESULT, 8'h77);
		bus_read(sac_pkg::OFS_RESULT, 32'h22);
		bus_read(sac_pkg::OFS_STATUS_CONTROL, 32'h02);
		// done written high with interrupts on blocks the request
		bus_write(sac_pkg::OFS_STATUS_CONTROL, 8'hC2);
		bus_write(sac_pkg::OFS_STATUS_CONTROL, 8'hC2);
		cycles(40);
		check(irq_out, 1'b0);
		bus_read(sac_pkg::OFS_STATUS_CONTROL, 32'hC2);
		// continuous conversions track the input without software
		bus_write(sac_pkg::OFS_STATUS_CONTROL, 8'h25);
		starts = 0;
		cycles(60);
		bus_read(sac_pkg::OFS_STATUS_CONTROL, 32'hA5);
		bus_read(sac_pkg::OFS_RESULT, 32'h55);
		bus_read(sac_pkg::OFS_STATUS_CONTROL, 32'h25);
		@(posedge clock_in);
		level_ofs <= 8'h03;
		cycles(60);
		bus_read(sac_pkg::OFS_RESULT, 32'h58);
		check(starts >= 4, 1'b1);
		// restart on a write in mid-conversion
		bus_write(sac_pkg::OFS_STATUS_CONTROL, 8'h42);
		cycles(5);
		conv_time(8'h46, 1);
		bus_read(sac_pkg::OFS_RESULT, 32'h69);
		// stop mode aborts, exit resumes
		bus_write(sac_pkg::OFS_STATUS_CONTROL, 8'h41);
		@(posedge clock_in);
		stop_mode <= 1'b1;
		cycles(60);
		check(irq_out, 1'b0);
		@(posedge clock_in);
		stop_mode <= 1'b0;
		cycles(40);
		check(irq_out, 1'b1);
		bus_read(sac_pkg::OFS_RESULT, 32'h14);
		bus_write(sac_pkg::OFS_STATUS_CONTROL, 8'h1F);
		cycles(4);
		check(sar_power, 1'b0);
		check(an_en, 8'h00);
		wrap_up();
	end
endmodule : tb_top
`default_nettype wire
